// file: include/pwmsh_pkg.sv
// Constants and register map for the PWM output shaping block.
// How it works
// - Third A bridge bit: 0 half, 1 full.
// - Third B bridge bit: 0 half, 1 full.
// - Shaping settings writable only during power-down.
// - Minus disable bit turns off half-bridge minus.
// - Minus disable ignored for full-bridge channels.
// - Common minimum pulse, 0 to 31 periods.
// - Minus output lags plus by skew periods.
// - A pair lags B pair by delay periods.
// - Rejection enable bit drives its pin level.
// - Rejection reset pin low while bit is 0.
// - Feedback logic enabled only while bit set.
// - Sync clock is crystal divided by 2^(4+code), codes 1 to 6.
// - Shift and 19-bit scale layout, MSB first.
// - Coefficient is signed 1.18 scale times 2^shift.
package pwmsh_pkg;
    // Register indexes; the APB byte address is four times the index.
    localparam logic [7:0] IDX_POWER = 8'h02;
    localparam logic [7:0] IDX_PWM_CFG = 8'h31;
    localparam logic [7:0] IDX_MIN_PULSE = 8'h32;
    localparam logic [7:0] IDX_DELAY = 8'h33;
    localparam logic [7:0] IDX_SUPPLY = 8'h34;
    localparam logic [7:0] IDX_DEC_HI = 8'h35;
    localparam logic [7:0] IDX_DEC_MID = 8'h36;
    localparam logic [7:0] IDX_DEC_LO = 8'h37;
    localparam int ADDR_W = 12;

    // Field positions.
    localparam int BIT_POWER_DOWN = 0;
    localparam int BIT_THIRD_A = 2;
    localparam int BIT_THIRD_B = 1;
    localparam int BIT_MINUS_DIS = 7;
    localparam int MIN_PULSE_LSB = 0;
    localparam int SKEW_LSB = 5;
    localparam int SIDE_LSB = 0;
    localparam int BIT_SR_ENABLE = 7;
    localparam int BIT_SR_RESET = 6;
    localparam int BIT_FEEDBACK = 5;
    localparam int SYNC_LSB = 0;
    localparam int SHIFT_LSB = 4;
    localparam int SCALE_HI_LSB = 0;

    // Writable bits of each register; the rest read as zero.
    localparam logic [7:0] MASK_POWER = 8'h01;
    localparam logic [7:0] MASK_PWM_CFG = 8'h06;
    localparam logic [7:0] MASK_MIN_PULSE = 8'h9f;
    localparam logic [7:0] MASK_DELAY = 8'hff;
    localparam logic [7:0] MASK_SUPPLY = 8'he7;
    localparam logic [7:0] MASK_DEC_HI = 8'h77;
    localparam logic [7:0] MASK_DEC_BYTE = 8'hff;

    // Reset values.
    localparam logic [7:0] RST_POWER = 8'h01;
    localparam logic [7:0] RST_PWM_CFG = 8'h00;
    localparam logic [7:0] RST_MIN_PULSE = 8'h00;
    localparam logic [7:0] RST_DELAY = 8'h00;
    localparam logic [7:0] RST_SUPPLY = 8'h00;
    localparam logic [7:0] RST_DEC_HI = 8'h22;
    localparam logic [7:0] RST_DEC_MID = 8'h58;
    localparam logic [7:0] RST_DEC_LO = 8'h68;

    // Sync divider: code 1 selects divide by 32, i.e. counter bit 4.
    localparam int SYNC_CNT_W = 10;
    localparam logic [2:0] SYNC_CODE_OFF = 3'h0;
    localparam logic [2:0] SYNC_CODE_MAX = 3'h6;
    localparam logic [3:0] SYNC_BASE_BIT = 4'h4;

    // Channel shaping geometry, counted in PWM master clock periods.
    localparam int NUM_CH = 6;
    localparam int HIST_W = 39;
    localparam logic [4:0] RUN_MAX = 5'h1f;
    localparam int COEF_W = 26;
endpackage

// file: core/pwmsh_channel.sv
// One PWM channel: minimum pulse stretch, delays and minus output gating.
`timescale 1ns/1ps
module pwmsh_channel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mod_pos,
    input wire logic mod_neg,
    input wire logic [4:0] min_pulse,
    input wire logic [4:0] side_delay,
    input wire logic [2:0] skew,
    input wire logic neg_off,
    output logic pwm_pos,
    output logic pwm_neg
);
    logic pos_shp_r, pos_shp_nxt, neg_shp_r, neg_shp_nxt;
    logic [4:0] pos_run_r, pos_run_nxt, neg_run_r, neg_run_nxt;
    logic [pwmsh_pkg::HIST_W-1:0] pos_hist_r, pos_hist_nxt;
    logic [pwmsh_pkg::HIST_W-1:0] neg_hist_r, neg_hist_nxt;
    logic pos_out_r, pos_out_nxt, neg_out_r, neg_out_nxt;

    // A level may only change once it has stood min cycles.
    function automatic logic [5:0] shape_step(input logic want,
            input logic cur, input logic [4:0] run, input logic [4:0] mn);
        logic [4:0] r;
        r = (run == pwmsh_pkg::RUN_MAX) ? run : run + 5'h01;
        if (want != cur && run >= mn) begin
            shape_step = {want, 5'h01};
        end else begin
            shape_step = {cur, r};
        end
    endfunction

    // Delay tap: zero means the current value, n means n cycles ago.
    function automatic logic tap(input logic [pwmsh_pkg::HIST_W-1:0] h,
            input logic cur, input logic [5:0] n);
        if (n == 6'h00) begin
            tap = cur;
        end else begin
            tap = h[n - 6'h01];
        end
    endfunction

    // Both outputs get the same minimum so the pair stays symmetric.
    always_comb begin
        {pos_shp_nxt, pos_run_nxt} =
            shape_step(mod_pos, pos_shp_r, pos_run_r, min_pulse);
        {neg_shp_nxt, neg_run_nxt} =
            shape_step(mod_neg, neg_shp_r, neg_run_r, min_pulse);
        pos_hist_nxt = {pos_hist_r[pwmsh_pkg::HIST_W-2:0], pos_shp_r};
        neg_hist_nxt = {neg_hist_r[pwmsh_pkg::HIST_W-2:0], neg_shp_r};
        pos_out_nxt = tap(pos_hist_r, pos_shp_r, {1'b0, side_delay});
        // Minus sees the side delay plus its own skew.
        neg_out_nxt = tap(neg_hist_r, neg_shp_r,
            {1'b0, side_delay} + {3'h0, skew});
        if (neg_off) begin
            neg_out_nxt = 1'b0;
        end
    end

    // Run counters start saturated so the first edge is never held.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_shp_r <= 1'b0;
            neg_shp_r <= 1'b0;
            pos_run_r <= pwmsh_pkg::RUN_MAX;
            neg_run_r <= pwmsh_pkg::RUN_MAX;
            pos_hist_r <= '0;
            neg_hist_r <= '0;
            pos_out_r <= 1'b0;
            neg_out_r <= 1'b0;
        end else begin
            pos_shp_r <= pos_shp_nxt;
            neg_shp_r <= neg_shp_nxt;
            pos_run_r <= pos_run_nxt;
            neg_run_r <= neg_run_nxt;
            pos_hist_r <= pos_hist_nxt;
            neg_hist_r <= neg_hist_nxt;
            pos_out_r <= pos_out_nxt;
            neg_out_r <= neg_out_nxt;
        end
    end

    assign pwm_pos = pos_out_r;
    assign pwm_neg = neg_out_r;
endmodule

// file: core/pwmsh_top.sv
// APB register file, supply rejection controls and six shaped PWM channels.
`timescale 1ns/1ps
module pwmsh_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwmsh_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] mod_pos,
    input wire logic [5:0] mod_neg,
    input wire logic [3:0] pair12_full_bridge,
    output logic [5:0] pwm_positive_output,
    output logic [5:0] pwm_negative_output,
    output logic supply_rejection_enable,
    output logic supply_rejection_reset_n,
    output logic feedback_enable,
    output logic supply_sync_clock,
    output logic global_power_down,
    output logic [2:0] dec_shift,
    output logic [18:0] dec_scale,
    output logic [pwmsh_pkg::COEF_W-1:0] supply_coefficient
);
    logic rst_meta_r, rst_n_r;

    logic [7:0] power_r, power_nxt;
    logic [7:0] pwm_cfg_r, pwm_cfg_nxt;
    logic [7:0] min_pulse_r, min_pulse_nxt;
    logic [7:0] delay_r, delay_nxt;
    logic [7:0] supply_r, supply_nxt;
    logic [7:0] dec_hi_r, dec_hi_nxt;
    logic [7:0] dec_mid_r, dec_mid_nxt;
    logic [7:0] dec_lo_r, dec_lo_nxt;

    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r;
    logic pslverr_r, pslverr_nxt;

    logic [pwmsh_pkg::SYNC_CNT_W-1:0] sync_cnt_r, sync_cnt_nxt;
    logic sync_clk_r, sync_clk_nxt;
    logic [pwmsh_pkg::COEF_W-1:0] coef_r, coef_nxt;

    logic addr_ok;
    logic [7:0] idx;
    logic setup_ph;
    logic wr_take;
    logic shaping_open;
    logic [5:0] full_bridge;
    logic [5:0] neg_off;
    logic [18:0] scale_val;
    logic [2:0] shift_val;

    // Reset is released through two flops so no flop sees a ragged edge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // Address decode: word aligned and inside the index range only.
    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i == pwmsh_pkg::IDX_POWER)
            || (i >= pwmsh_pkg::IDX_PWM_CFG && i <= pwmsh_pkg::IDX_DEC_LO);
    endfunction

    // Merge a byte write through the writable-bit mask.
    function automatic logic [7:0] merge(input logic [7:0] d,
            input logic [7:0] m);
        merge = d & m;
    endfunction

    assign idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00)
        && is_mapped(idx);
    assign setup_ph = psel && !penable;
    // The slave never inserts wait states, so the access edge is the
    // only moment a write can take effect.
    assign wr_take = psel && penable && pready_r && pwrite && pstrb[0];
    // Changing the shaping while modulators run would glitch the bridge.
    assign shaping_open = power_r[pwmsh_pkg::BIT_POWER_DOWN];

    // Register writes: shaping settings only move during power-down.
    always_comb begin
        power_nxt = power_r;
        pwm_cfg_nxt = pwm_cfg_r;
        min_pulse_nxt = min_pulse_r;
        delay_nxt = delay_r;
        supply_nxt = supply_r;
        dec_hi_nxt = dec_hi_r;
        dec_mid_nxt = dec_mid_r;
        dec_lo_nxt = dec_lo_r;
        if (wr_take && addr_ok) begin
            unique case (idx)
                pwmsh_pkg::IDX_POWER: begin
                    power_nxt = merge(pwdata[7:0], pwmsh_pkg::MASK_POWER);
                end
                pwmsh_pkg::IDX_PWM_CFG: begin
                    if (shaping_open) begin
                        pwm_cfg_nxt = merge(pwdata[7:0],
                            pwmsh_pkg::MASK_PWM_CFG);
                    end
                end
                pwmsh_pkg::IDX_MIN_PULSE: begin
                    if (shaping_open) begin
                        min_pulse_nxt = merge(pwdata[7:0],
                            pwmsh_pkg::MASK_MIN_PULSE);
                    end
                end
                pwmsh_pkg::IDX_DELAY: begin
                    if (shaping_open) begin
                        delay_nxt = merge(pwdata[7:0],
                            pwmsh_pkg::MASK_DELAY);
                    end
                end
                pwmsh_pkg::IDX_SUPPLY: begin
                    supply_nxt = merge(pwdata[7:0], pwmsh_pkg::MASK_SUPPLY);
                end
                pwmsh_pkg::IDX_DEC_HI: begin
                    dec_hi_nxt = merge(pwdata[7:0],
                        pwmsh_pkg::MASK_DEC_HI);
                end
                pwmsh_pkg::IDX_DEC_MID: begin
                    dec_mid_nxt = merge(pwdata[7:0],
                        pwmsh_pkg::MASK_DEC_BYTE);
                end
                pwmsh_pkg::IDX_DEC_LO: begin
                    dec_lo_nxt = merge(pwdata[7:0],
                        pwmsh_pkg::MASK_DEC_BYTE);
                end
                default: begin
                    power_nxt = power_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            power_r <= pwmsh_pkg::RST_POWER;
            pwm_cfg_r <= pwmsh_pkg::RST_PWM_CFG;
            min_pulse_r <= pwmsh_pkg::RST_MIN_PULSE;
            delay_r <= pwmsh_pkg::RST_DELAY;
            supply_r <= pwmsh_pkg::RST_SUPPLY;
            dec_hi_r <= pwmsh_pkg::RST_DEC_HI;
            dec_mid_r <= pwmsh_pkg::RST_DEC_MID;
            dec_lo_r <= pwmsh_pkg::RST_DEC_LO;
        end else begin
            power_r <= power_nxt;
            pwm_cfg_r <= pwm_cfg_nxt;
            min_pulse_r <= min_pulse_nxt;
            delay_r <= delay_nxt;
            supply_r <= supply_nxt;
            dec_hi_r <= dec_hi_nxt;
            dec_mid_r <= dec_mid_nxt;
            dec_lo_r <= dec_lo_nxt;
        end
    end

    // Read data and error are latched in the setup cycle, so they are
    // stable from flops through the whole access phase.
    always_comb begin
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup_ph) begin
            pslverr_nxt = !addr_ok;
            prdata_nxt = 32'h0000_0000;
            if (addr_ok && !pwrite) begin
                unique case (idx)
                    pwmsh_pkg::IDX_POWER: prdata_nxt[7:0] = power_r;
                    pwmsh_pkg::IDX_PWM_CFG: prdata_nxt[7:0] = pwm_cfg_r;
                    pwmsh_pkg::IDX_MIN_PULSE: prdata_nxt[7:0] = min_pulse_r;
                    pwmsh_pkg::IDX_DELAY: prdata_nxt[7:0] = delay_r;
                    pwmsh_pkg::IDX_SUPPLY: prdata_nxt[7:0] = supply_r;
                    pwmsh_pkg::IDX_DEC_HI: prdata_nxt[7:0] = dec_hi_r;
                    pwmsh_pkg::IDX_DEC_MID: prdata_nxt[7:0] = dec_mid_r;
                    pwmsh_pkg::IDX_DEC_LO: prdata_nxt[7:0] = dec_lo_r;
                    default: prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            pready_r <= 1'b1;
        end
    end

    // Sync divider: a free counter, one bit picked by the code. The
    // counter never stops so a code change takes effect at once, at the
    // price of one short half period on the switch.
    always_comb begin
        sync_cnt_nxt = sync_cnt_r + {{(pwmsh_pkg::SYNC_CNT_W-1){1'b0}}, 1'b1};
        sync_clk_nxt = 1'b0;
        if (supply_r[pwmsh_pkg::SYNC_LSB +: 3] != pwmsh_pkg::SYNC_CODE_OFF
            && supply_r[pwmsh_pkg::SYNC_LSB +: 3]
               <= pwmsh_pkg::SYNC_CODE_MAX) begin
            sync_clk_nxt = sync_cnt_r[pwmsh_pkg::SYNC_BASE_BIT
                + {1'b0, supply_r[pwmsh_pkg::SYNC_LSB +: 3]}
                - 4'h1];
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sync_cnt_r <= '0;
            sync_clk_r <= 1'b0;
        end else begin
            sync_cnt_r <= sync_cnt_nxt;
            sync_clk_r <= sync_clk_nxt;
        end
    end

    // Coefficient: sign-extended 1.18 scale shifted left by shift.
    assign scale_val = {dec_hi_r[pwmsh_pkg::SCALE_HI_LSB +: 3],
        dec_mid_r, dec_lo_r};
    assign shift_val = dec_hi_r[pwmsh_pkg::SHIFT_LSB +: 3];

    always_comb begin
        coef_nxt = {{(pwmsh_pkg::COEF_W-19){scale_val[18]}}, scale_val}
            <<< shift_val;
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            coef_r <= '0;
        end else begin
            coef_r <= coef_nxt;
        end
    end

    // Bridge mode per channel; order A1 B1 A2 B2 A3 B3.
    assign full_bridge = {pwm_cfg_r[pwmsh_pkg::BIT_THIRD_B],
        pwm_cfg_r[pwmsh_pkg::BIT_THIRD_A], pair12_full_bridge};
    // Minus disable only bites on half-bridge channels.
    assign neg_off = {6{min_pulse_r[pwmsh_pkg::BIT_MINUS_DIS]}}
        & ~full_bridge;

    // A channels sit at even positions and carry the side delay.
    for (genvar ch = 0; ch < pwmsh_pkg::NUM_CH; ch++) begin : g_ch
        pwmsh_channel u_ch (
            .clk(clk),
            .rst_n(rst_n_r),
            .mod_pos(mod_pos[ch]),
            .mod_neg(mod_neg[ch]),
            .min_pulse(min_pulse_r[pwmsh_pkg::MIN_PULSE_LSB +: 5]),
            .side_delay((ch % 2 == 0)
                ? delay_r[pwmsh_pkg::SIDE_LSB +: 5] : 5'h00),
            .skew(delay_r[pwmsh_pkg::SKEW_LSB +: 3]),
            .neg_off(neg_off[ch]),
            .pwm_pos(pwm_positive_output[ch]),
            .pwm_neg(pwm_negative_output[ch])
        );
    end

    // Supply enable, reset and feedback pins follow their register bits directly; the sync pin comes from the divider.
    assign supply_rejection_enable = supply_r[pwmsh_pkg::BIT_SR_ENABLE];
    assign supply_rejection_reset_n =
        supply_r[pwmsh_pkg::BIT_SR_RESET];
    assign feedback_enable = supply_r[pwmsh_pkg::BIT_FEEDBACK];
    assign supply_sync_clock = sync_clk_r;
    assign global_power_down = power_r[pwmsh_pkg::BIT_POWER_DOWN];
    assign dec_shift = shift_val;
    assign dec_scale = scale_val;
    assign supply_coefficient = coef_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
endmodule

// file: test/pwmsh_monitor.sv
// Checker for the register, bus and supply ports of the shaping block.
`timescale 1ns/1ps
module pwmsh_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwmsh_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic supply_rejection_enable,
    input wire logic supply_rejection_reset_n,
    input wire logic feedback_enable,
    input wire logic global_power_down,
    input wire logic [2:0] dec_shift,
    input wire logic [18:0] dec_scale,
    input wire logic [pwmsh_pkg::COEF_W-1:0] supply_coefficient
);
    logic [2:0] up_r;
    logic [2:0] up_nxt;
    logic ok;
    logic hit;
    logic [pwmsh_pkg::COEF_W-1:0] coef;
    // The core keeps reset two edges longer, so settle before judging.
    always_comb begin
        up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            up_r <= 3'h0;
        end else begin
            up_r <= up_nxt;
        end
    end
    // Mapped words: power register and the block from 0x31 to 0x37.
    assign ok = (up_r == 3'h7);
    assign hit = (paddr == 12'h008) ||
        (paddr >= 12'hc4 && paddr <= 12'hdc && paddr[1:0] == 2'h0);
    assign coef = {{7{dec_scale[18]}}, dec_scale} <<< dec_shift;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_wr(logic [11:0] a);
        psel && penable && pready && pwrite && pstrb[0] && paddr == a;
    endsequence
    property p_sr_en;
        s_wr(12'hd0) |=> supply_rejection_enable == $past(pwdata[7]);
    endproperty
    a_sr_en: assert property (p_sr_en)
        else $error("supply enable pin does not follow its bit");
    property p_sr_rst;
        s_wr(12'hd0) |=> supply_rejection_reset_n == $past(pwdata[6]);
    endproperty
    a_sr_rst: assert property (p_sr_rst)
        else $error("supply reset pin does not follow its bit");
    property p_rst_hold;
        !supply_rejection_reset_n && !(psel && pwrite && paddr == 12'hd0)
            |=> !supply_rejection_reset_n;
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("supply reset released without a write");
    property p_fb;
        s_wr(12'hd0) |=> feedback_enable == $past(pwdata[5]);
    endproperty
    a_fb: assert property (p_fb)
        else $error("feedback enable does not follow its bit");
    property p_shift;
        s_wr(12'hd4) |=> dec_shift == $past(pwdata[6:4]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("decimator shift field misplaced");
    property p_low;
        s_wr(12'hdc) |=> dec_scale[7:0] == $past(pwdata[7:0]);
    endproperty
    a_low: assert property (p_low)
        else $error("decimator scale low byte misplaced");
    property p_coef;
        ok |=> supply_coefficient == $past(coef);
    endproperty
    a_coef: assert property (p_coef)
        else $error("supply coefficient wrong");
    property p_pwd;
        s_wr(12'h008) |=> global_power_down == $past(pwdata[0]);
    endproperty
    a_pwd: assert property (p_pwd)
        else $error("power down bit not stored");
    property p_rdy;
        ok |-> pready;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("ready dropped");
    property p_err;
        psel && !penable |=> pslverr == !$past(hit);
    endproperty
    a_err: assert property (p_err)
        else $error("error flag wrong for address");
endmodule

bind pwmsh_top pwmsh_monitor u_mon (.clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
    .supply_rejection_enable, .supply_rejection_reset_n, .feedback_enable,
    .global_power_down, .dec_shift, .dec_scale, .supply_coefficient);

// file: test/pwmsh_partner.sv
// Model of the external supply rejection board measuring the sync clock.
`timescale 1ns/1ps
module pwmsh_partner (
    input wire logic clk,
    input wire logic supply_rejection_enable,
    input wire logic supply_rejection_reset_n,
    input wire logic supply_sync_clock,
    output int rises,
    output int period
);
    int cnt;
    logic last;
    // The board only counts while enabled and out of its reset.
    always @(posedge clk) begin
        last <= supply_sync_clock;
        cnt <= cnt + 1;
        if (!supply_rejection_reset_n || !supply_rejection_enable) begin
            rises <= 0;
            cnt <= 0;
        end else if (supply_sync_clock && !last) begin
            rises <= rises + 1;
            period <= cnt + 1;
            cnt <= 0;
        end
    end
endmodule

// file: test/tb.sv
// Self-checking bench for the PWM shaping and supply control block.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t: got %0h want %0h", $time, a, b); end end
module tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, sre, srr, fbe, sync, pwd;
    logic [5:0] mod_pos = 6'h0;
    logic [5:0] mod_neg = 6'h0;
    logic [3:0] pair12 = 4'h0;
    logic [5:0] pos, neg, nm;
    logic [2:0] shift;
    logic [18:0] scale;
    logic [25:0] coef;
    logic [31:0] rd;
    logic err;
    int rises, period, errors, comparisons, base, n;
    int rp[6], rn[6], hp[6], hn[6];
    localparam logic [7:0] RI [8] = '{8'h02, 8'h31, 8'h32, 8'h33, 8'h34,
        8'h35, 8'h36, 8'h37};
    localparam logic [7:0] RV [8] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h22, 8'h58, 8'h68};
    localparam logic [7:0] DL [3] = '{8'h00, 8'h65, 8'hff};
    localparam logic [7:0] TC [5] = '{8'h00, 8'h04, 8'h02, 8'h00, 8'h00};
    localparam logic [3:0] TP [5] = '{4'h0, 4'h0, 4'h0, 4'h5, 4'h0};
    localparam logic [7:0] TM [5] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
    localparam logic [5:0] TN [5] = '{6'h00, 6'h10, 6'h20, 6'h05, 6'h3f};

    pwmsh_top uut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .mod_pos, .mod_neg,
        .pair12_full_bridge(pair12), .pwm_positive_output(pos),
        .pwm_negative_output(neg), .supply_rejection_enable(sre),
        .supply_rejection_reset_n(srr), .feedback_enable(fbe),
        .supply_sync_clock(sync), .global_power_down(pwd),
        .dec_shift(shift), .dec_scale(scale), .supply_coefficient(coef));
    pwmsh_partner u_psr (.clk, .supply_rejection_enable(sre),
        .supply_rejection_reset_n(srr), .supply_sync_clock(sync),
        .rises, .period);

    always #5 clk = ~clk;

    task automatic end_of_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One APB transfer; the request holds until ready is seen high.
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k == 50) begin
            errors++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask
    task automatic rchk(input logic [7:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        `CHK(rd[7:0], e)
    endtask

    // Raise every modulator line for len cycles and log edges and widths.
    task automatic run(input int len);
        for (int i = 0; i < 6; i++) begin
            rp[i] = -1;
            rn[i] = -1;
            hp[i] = 0;
            hn[i] = 0;
        end
        mod_pos <= 6'h3f;
        mod_neg <= 6'h3f;
        for (int t = 1; t < 80; t++) begin
            @(posedge clk);
            if (t == len) begin
                mod_pos <= 6'h00;
                mod_neg <= 6'h00;
            end
            #1;
            for (int i = 0; i < 6; i++) begin
                if (pos[i] === 1'b1 && rp[i] < 0) rp[i] = t;
                if (neg[i] === 1'b1 && rn[i] < 0) rn[i] = t;
                hp[i] += (pos[i] === 1'b1);
                hn[i] += (neg[i] === 1'b1);
            end
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK({sre, srr, fbe, sync, pwd}, 5'b00001)
        `CHK(coef, 26'h00961a0)
        for (int i = 0; i < 8; i++) rchk(RI[i], RV[i]);
        apb(1'b0, 8'h40, 8'h00);
        `CHK({err, rd}, {1'b1, 32'h0})
        // Shaping settings must be refused while the modulator runs.
        wr(8'h02, 8'h00);
        `CHK(pwd, 1'b0)
        wr(8'h31, 8'h06);
        wr(8'h32, 8'h9f);
        wr(8'h33, 8'hff);
        for (int i = 1; i < 4; i++) rchk(RI[i], 8'h00);
        wr(8'h35, 8'hff);
        wr(8'h36, 8'h12);
        wr(8'h37, 8'h34);
        rchk(8'h35, 8'h77);
        `CHK({shift, scale}, {3'h7, 19'h71234})
        `CHK(coef, 26'h3891a00)
        wr(8'h02, 8'h01);
        wr(8'h32, 8'h9f);
        rchk(8'h32, 8'h9f);
        // Delays: A side lags B by the side count, minus lags by skew.
        pair12 <= 4'hf;
        wr(8'h31, 8'h06);
        wr(8'h32, 8'h00);
        foreach (DL[j]) begin
            wr(8'h33, DL[j]);
            run(4);
            for (int i = 0; i < 6; i++) begin
                `CHK(rp[i], 2 + ((i % 2) ? 0 : int'(DL[j][4:0])))
                `CHK(rn[i] - rp[i], int'(DL[j][7:5]))
                `CHK(hp[i], 4)
            end
        end
        // A one-cycle pulse is stretched to the minimum on both outputs.
        wr(8'h33, 8'h00);
        foreach (DL[j]) begin
            n = (j == 0) ? 0 : ((j == 1) ? 6 : 31);
            wr(8'h32, n[7:0]);
            run(1);
            for (int i = 0; i < 6; i++) begin
                `CHK(hp[i], (n > 0) ? n : 1)
                `CHK(hn[i], (n > 0) ? n : 1)
            end
        end
        // Minus gating applies only to half-bridge channels.
        foreach (TC[j]) begin
            pair12 <= TP[j];
            wr(8'h31, TC[j]);
            wr(8'h32, TM[j]);
            run(4);
            for (int i = 0; i < 6; i++) nm[i] = (hn[i] > 0);
            `CHK(nm, TN[j])
        end
        wr(8'h34, 8'h80);
        `CHK({sre, srr, fbe}, 3'b100)
        `CHK(rises, 0)
        for (int k = 1; k < 9; k++) begin
            wr(8'h34, 8'he0 | (k % 8));
            `CHK({sre, srr, fbe}, 3'b111)
            base = rises;
            n = 0;
            while (k < 7 && rises < base + 3 && n < 4000) begin
                @(posedge clk);
                n++;
            end
            // A sync clock that never toggles must not hang the run.
            if (n == 4000) begin
                errors++;
                end_of_test();
            end
            if (k < 7) `CHK(period, 1 << (4 + k))
            n = 0;
            repeat (40) begin
                @(posedge clk);
                n += (k > 6 && sync !== 1'b0);
            end
            `CHK(n, 0)
        end
        end_of_test();
    end
endmodule
